/* design/fpl_defines.svh */
`ifndef FPL_DEFINES_SVH
`define FPL_DEFINES_SVH

// clocking and timing
`define FPL_SYS_CLK_HZ      50000000
`define FPL_UART_INIT_BPS   9600
`define FPL_UART_INIT_CYC   (`FPL_SYS_CLK_HZ / `FPL_UART_INIT_BPS)
`define FPL_SEL_QUIET_US    1000
`define FPL_SEL_QUIET_CYC   (`FPL_SEL_QUIET_US * (`FPL_SYS_CLK_HZ / 1000000))
`define FPL_AUTOBAUD_BITS   9
`define FPL_BAUD_W          16

// pulse counts that pick a link
`define FPL_PULSES_MAX      12
`define FPL_PULSES_CSI      4'h8
`define FPL_PULSES_CSI_HS   4'hb
`define FPL_PULSES_UART     4'h0

// response codes
`define FPL_RESP_ACK        8'h06
`define FPL_RESP_NAK        8'h15

// command codes taken as legal
`define FPL_CMD_RESET       8'h00
`define FPL_CMD_BLANK       8'h32
`define FPL_CMD_CHIP_ERASE  8'h20
`define FPL_CMD_BLK_ERASE   8'h22
`define FPL_CMD_WRITE       8'h40
`define FPL_CMD_VERIFY      8'h13
`define FPL_CMD_OSC         8'h90
`define FPL_CMD_BAUD        8'h9a
`define FPL_CMD_SIGNATURE   8'hc0
`define FPL_CMD_VERSION     8'hc5
`define FPL_CMD_STATUS      8'h70
`define FPL_CMD_SECURITY    8'ha0

// general port pins held off in programming mode
`define FPL_PORT_W          16

`endif

/* design/fpl_mode_link.sv */
// Functional notes
// R1: enable pin low gives normal operation
// R2: qualifier pin ignored while enable pin low
// R3: programming only with enable high, qualifier low
// R4: unused pins keep their reset state
// R5: port pins high impedance unless link uses them
// R6: async link spans 9600 to 153600 bps
// R7: clocked link 2.4 kHz-2.5 MHz, MSB first
// R8: programmer makes clock, device shifts as slave
// R9: each link drives only its own pins
// R10: handshake variant drives handshake pin out
// R11: only the programmer resets during programming
// R12: programmer never drives debug reset high
// R13: mode pins sampled at reset release, held
// R14: count up to twelve enable-pin pulses
// R15: 8 clocked, 11 handshake, 0 async, others reserved
// R16: async bit timing measured from reset command
// R17: every command answered with ack or nak
`timescale 1ns/10ps
`default_nettype none
`include "fpl_defines.svh"

module fpl_mode_link
  import fpl_pkg::*;
#(
  parameter int SEL_QUIET_CYC = `FPL_SEL_QUIET_CYC,
  parameter int UART_INIT_CYC = `FPL_UART_INIT_CYC
) (
  // system clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  // mode pins
  input  wire logic                   i_program_enable_pin,
  input  wire logic                   i_program_qualifier_pin,
  // clocked serial link pins
  input  wire logic                   i_csi_serial_clock,
  input  wire logic                   i_csi_data_in,
  output logic                        o_csi_data_out,
  output logic                        o_csi_data_out_oe_n,
  output logic                        o_handshake_pin,
  output logic                        o_handshake_pin_oe_n,
  // async serial link pins
  input  wire logic                   i_uart_receive_pin,
  output logic                        o_uart_transmit_pin,
  output logic                        o_uart_transmit_pin_oe_n,
  // application port control
  input  wire logic [`FPL_PORT_W-1:0] i_app_port_oe_n,
  output logic [`FPL_PORT_W-1:0]      o_port_oe_n,
  // mode status
  output logic                        o_normal_mode,
  output logic                        o_program_mode,
  output logic                        o_link_reserved
);

  // pin synchronisers, first stage feeds only the second
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  wire  [4:0] pin_raw = {i_csi_serial_clock, i_uart_receive_pin, 1'b0,
                         i_program_qualifier_pin, i_program_enable_pin};
  wire        en_pin   = pin_s2_q[0];
  wire        qual_pin = pin_s2_q[1];
  wire        rxd      = pin_s2_q[3];

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pin_s1_q <= 5'h18;  // idle high for uart line
      pin_s2_q <= 5'h18;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // state registers
  fpl_mode_t  mode_q, mode_d;
  logic [1:0] cap_cnt_q;                // waits for synchronised pins
  logic [3:0] pulse_q;                  // enable pin pulse count
  logic [16:0] quiet_q;                 // quiet time since last pulse
  logic        en_prev_q;
  logic        reserved_q;

  // pin decode; qualifier only matters when enable is high
  wire cap_done    = (cap_cnt_q == 2'h2);
  wire pick_normal = !en_pin;                      // R1 R2
  wire pick_prog   = en_pin && !qual_pin;          // R3
  wire pulse_fall  = en_prev_q && !en_pin;
  wire quiet_end   = (quiet_q == 17'(SEL_QUIET_CYC));
  wire in_csi      = (mode_q == FPL_ST_CSI) || (mode_q == FPL_ST_CSI_HS);
  wire in_uart     = (mode_q == FPL_ST_UART);

  // mode decision: taken once after reset, then held
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      FPL_ST_CAPTURE: begin
        if (cap_done) begin  // R13
          if (pick_normal)    mode_d = FPL_ST_NORMAL;
          else if (pick_prog) mode_d = FPL_ST_SELECT;
          else                mode_d = FPL_ST_PROHIBIT;
        end
      end
      FPL_ST_SELECT: begin
        if (quiet_end) begin  // R15
          if (pulse_q == `FPL_PULSES_CSI)         mode_d = FPL_ST_CSI;
          else if (pulse_q == `FPL_PULSES_CSI_HS) mode_d = FPL_ST_CSI_HS;
          else if (pulse_q == `FPL_PULSES_UART)   mode_d = FPL_ST_UART;
          else                                    mode_d = FPL_ST_PROHIBIT;
        end
      end
      FPL_ST_NORMAL,
      FPL_ST_PROHIBIT,
      FPL_ST_CSI,
      FPL_ST_CSI_HS,
      FPL_ST_UART:    mode_d = mode_q;
      default:        mode_d = FPL_ST_CAPTURE;
    endcase
  end

  // mode register, pulse counter and quiet timer
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mode_q    <= FPL_ST_CAPTURE;
      cap_cnt_q <= 2'h0;
      pulse_q   <= 4'h0;
      quiet_q   <= 17'h0;
      en_prev_q <= 1'b1;
    end else begin
      mode_q    <= mode_d;
      en_prev_q <= en_pin;
      if (!cap_done) cap_cnt_q <= cap_cnt_q + 2'h1;
      // saturate at fifteen so a longer burst stays reserved
      if (mode_q == FPL_ST_SELECT && pulse_fall) begin  // R14
        quiet_q <= 17'h0;
        if (pulse_q != 4'hf) pulse_q <= pulse_q + 4'h1;
      end else if (mode_q == FPL_ST_SELECT && !en_pin) begin
        quiet_q <= 17'h0;  // pulse still low
      end else if (mode_q == FPL_ST_SELECT && !quiet_end) begin
        quiet_q <= quiet_q + 17'h1;
      end
    end
  end

  // link side of the clocked port, runs on the programmer's clock
  logic [7:0] csi_sh_q;
  logic [7:0] csi_byte_q;
  logic [2:0] csi_bit_q;
  logic       csi_tog_q;
  logic [7:0] csi_tx_q;
  logic       csi_so_q;
  logic [7:0] resp_q;                   // held response, crosses as a word

  always_ff @(posedge i_csi_serial_clock or posedge i_reset) begin
    if (i_reset) begin
      csi_sh_q   <= 8'h00;
      csi_byte_q <= 8'h00;
      csi_bit_q  <= 3'h0;
      csi_tog_q  <= 1'b0;
    end else begin
      csi_sh_q  <= {csi_sh_q[6:0], i_csi_data_in};  // R7 R8
      csi_bit_q <= csi_bit_q + 3'h1;
      if (csi_bit_q == 3'h7) begin
        csi_byte_q <= {csi_sh_q[6:0], i_csi_data_in};
        csi_tog_q  <= !csi_tog_q;  // event crosses as a toggle
      end
    end
  end

  // shift out on the falling edge, msb first
  always_ff @(negedge i_csi_serial_clock or posedge i_reset) begin
    if (i_reset) begin
      csi_tx_q <= 8'hff;
      csi_so_q <= 1'b1;
    end else if (csi_bit_q == 3'h0) begin
      // response word is set shortly after the byte before ends, ahead of this load
      csi_tx_q <= {resp_q[6:0], 1'b1};
      csi_so_q <= resp_q[7];  // R7
    end else begin
      csi_tx_q <= {csi_tx_q[6:0], 1'b1};
      csi_so_q <= csi_tx_q[7];
    end
  end

  // byte-done toggle brought into the system clock
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  wire  csi_stb = in_csi && (tog_s2_q != tog_s3_q);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= csi_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // async receiver with bit time taken from the reset command
  fpl_rx_t                 rx_st_q;
  logic [`FPL_BAUD_W-1:0]  baud_q;      // cycles per bit
  logic [`FPL_BAUD_W-1:0]  rx_cnt_q;
  logic [3:0]              nine_q;      // divides the low time by nine
  logic [2:0]              rx_bit_q;
  logic [7:0]              rx_sh_q;
  logic                    rx_skip_q;   // first tick lands on the start bit
  logic                    rx_prev_q;
  logic                    uart_stb_q;
  logic [7:0]              uart_byte_q;
  wire                     rx_fall = rx_prev_q && !rxd;
  wire                     rx_tick = (rx_cnt_q == baud_q);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rx_st_q     <= FPL_RX_BAUD;
      baud_q      <= `FPL_BAUD_W'(UART_INIT_CYC);
      rx_cnt_q    <= '0;
      nine_q      <= 4'h0;
      rx_bit_q    <= 3'h0;
      rx_sh_q     <= 8'h00;
      rx_skip_q   <= 1'b0;
      rx_prev_q   <= 1'b1;
      uart_stb_q  <= 1'b0;
      uart_byte_q <= 8'h00;
    end else begin
      rx_prev_q  <= rxd;
      uart_stb_q <= 1'b0;
      case (rx_st_q)
        FPL_RX_BAUD: begin
          // start bit plus eight zero bits stay low for nine bit times
          if (in_uart && rx_fall) begin  // R16
            baud_q   <= '0;
            nine_q   <= 4'h0;
            rx_cnt_q <= 16'h1;
          end else if (in_uart && rx_cnt_q != '0 && !rxd) begin
            if (nine_q == 4'(`FPL_AUTOBAUD_BITS - 1)) begin
              nine_q <= 4'h0;
              baud_q <= baud_q + 16'h1;
            end else begin
              nine_q <= nine_q + 4'h1;
            end
          end else if (in_uart && rx_cnt_q != '0) begin
            rx_cnt_q    <= '0;
            rx_st_q     <= FPL_RX_IDLE;
            uart_byte_q <= `FPL_CMD_RESET;
            uart_stb_q  <= 1'b1;  // reset command gets its answer
          end
        end
        FPL_RX_IDLE: begin
          if (rx_fall) begin
            rx_cnt_q <= {1'b0, baud_q[`FPL_BAUD_W-1:1]};  // aim mid-bit
            rx_bit_q  <= 3'h0;
            rx_skip_q <= 1'b1;
            rx_st_q   <= FPL_RX_DATA;
          end
        end
        FPL_RX_DATA: begin
          if (rx_tick) begin
            rx_cnt_q  <= '0;
            rx_skip_q <= 1'b0;
            // mid start bit carries no data, only the ticks after it shift
            if (!rx_skip_q) begin
              rx_sh_q  <= {rxd, rx_sh_q[7:1]};  // lsb first
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) rx_st_q <= FPL_RX_STOP;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q + 16'h1;
          end
        end
        FPL_RX_STOP: begin
          if (rx_tick) begin
            rx_cnt_q    <= '0;
            rx_st_q     <= FPL_RX_IDLE;
            uart_byte_q <= rx_sh_q;
            uart_stb_q  <= rxd;  // framing error drops the byte
          end else begin
            rx_cnt_q <= rx_cnt_q + 16'h1;
          end
        end
        default: rx_st_q <= FPL_RX_IDLE;
      endcase
    end
  end

  // command check and response; the clocked byte is stable for a byte time
  wire [7:0] cmd_byte = in_csi ? csi_byte_q : uart_byte_q;
  wire       cmd_stb  = csi_stb || (in_uart && uart_stb_q);
  wire       cmd_ok   = (cmd_byte == `FPL_CMD_RESET)      ||
                        (cmd_byte == `FPL_CMD_BLANK)      ||
                        (cmd_byte == `FPL_CMD_CHIP_ERASE) ||
                        (cmd_byte == `FPL_CMD_BLK_ERASE)  ||
                        (cmd_byte == `FPL_CMD_WRITE)      ||
                        (cmd_byte == `FPL_CMD_VERIFY)     ||
                        (cmd_byte == `FPL_CMD_OSC)        ||
                        (cmd_byte == `FPL_CMD_BAUD)       ||
                        (cmd_byte == `FPL_CMD_SIGNATURE)  ||
                        (cmd_byte == `FPL_CMD_VERSION)    ||
                        (cmd_byte == `FPL_CMD_STATUS)     ||
                        (cmd_byte == `FPL_CMD_SECURITY);

  // async transmitter: start, eight data lsb first, stop
  logic [9:0]             tx_sh_q;
  logic [3:0]             tx_left_q;
  logic [`FPL_BAUD_W-1:0] tx_cnt_q;
  logic                   hs_q;
  wire  [7:0]             resp_d = cmd_ok ? `FPL_RESP_ACK : `FPL_RESP_NAK;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      resp_q    <= 8'hff;
      tx_sh_q   <= 10'h3ff;
      tx_left_q <= 4'h0;
      tx_cnt_q  <= '0;
      hs_q      <= 1'b1;
    end else begin
      if (cmd_stb) begin
        resp_q <= resp_d;  // R17
        hs_q   <= 1'b0;    // busy while the answer is prepared
      end else begin
        hs_q   <= 1'b1;    // R10
      end
      if (cmd_stb && in_uart) begin
        tx_sh_q   <= {1'b1, resp_d, 1'b0};
        tx_left_q <= 4'ha;
        tx_cnt_q  <= '0;
      end else if (tx_left_q != 4'h0) begin
        if (tx_cnt_q == baud_q) begin  // R6
          tx_cnt_q  <= '0;
          tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end else begin
          tx_cnt_q <= tx_cnt_q + 16'h1;
        end
      end
    end
  end

  // pin drive: only the chosen link leaves high impedance
  logic [`FPL_PORT_W-1:0] port_oe_n_q;
  logic                   so_oe_n_q;
  logic                   hs_oe_n_q;
  logic                   tx_oe_n_q;
  wire                    prog_any = (mode_q != FPL_ST_NORMAL) &&
                                     (mode_q != FPL_ST_CAPTURE);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      port_oe_n_q <= '1;
      so_oe_n_q   <= 1'b1;
      hs_oe_n_q   <= 1'b1;
      tx_oe_n_q   <= 1'b1;
      reserved_q  <= 1'b0;
    end else begin
      port_oe_n_q <= prog_any ? '1 : i_app_port_oe_n;        // R4 R5
      so_oe_n_q   <= !in_csi;                                // R9
      hs_oe_n_q   <= (mode_q != FPL_ST_CSI_HS);              // R9
      tx_oe_n_q   <= !in_uart;                               // R9
      reserved_q  <= (mode_q == FPL_ST_PROHIBIT);
    end
  end

  // outputs
  assign o_csi_data_out           = csi_so_q;
  assign o_csi_data_out_oe_n      = so_oe_n_q;
  assign o_handshake_pin          = hs_q;
  assign o_handshake_pin_oe_n     = hs_oe_n_q;
  assign o_uart_transmit_pin      = tx_sh_q[0];
  assign o_uart_transmit_pin_oe_n = tx_oe_n_q;
  assign o_port_oe_n              = port_oe_n_q;
  assign o_normal_mode            = (mode_q == FPL_ST_NORMAL);
  assign o_program_mode           = prog_any;
  assign o_link_reserved          = reserved_q;

  // unused synchroniser lanes kept for a regular structure
  wire unused_ok = &{1'b0, pin_s2_q[4], pin_s2_q[2]};

endmodule : fpl_mode_link
`default_nettype wire

/* design/fpl_pkg.sv */
package fpl_pkg;

  // operating and link selection states, one-hot
  typedef enum logic [6:0] {
    FPL_ST_CAPTURE  = 7'b000_0001,
    FPL_ST_NORMAL   = 7'b000_0010,
    FPL_ST_PROHIBIT = 7'b000_0100,
    FPL_ST_SELECT   = 7'b000_1000,
    FPL_ST_CSI      = 7'b001_0000,
    FPL_ST_CSI_HS   = 7'b010_0000,
    FPL_ST_UART     = 7'b100_0000
  } fpl_mode_t;

  // uart receiver states, one-hot
  typedef enum logic [3:0] {
    FPL_RX_BAUD  = 4'b0001,
    FPL_RX_IDLE  = 4'b0010,
    FPL_RX_DATA  = 4'b0100,
    FPL_RX_STOP  = 4'b1000
  } fpl_rx_t;

endpackage : fpl_pkg

/* sim/fpl_mode_link_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fpl_defines.svh"

module fpl_mode_link_props (
  // watched clock and reset
  input wire logic                   i_clk_sys,
  input wire logic                   i_reset,
  // watched pins and status
  input wire logic                   o_csi_data_out_oe_n,
  input wire logic                   o_handshake_pin,
  input wire logic                   o_handshake_pin_oe_n,
  input wire logic                   o_uart_transmit_pin_oe_n,
  input wire logic [`FPL_PORT_W-1:0] i_app_port_oe_n,
  input wire logic [`FPL_PORT_W-1:0] o_port_oe_n,
  input wire logic                   o_normal_mode,
  input wire logic                   o_program_mode,
  input wire logic                   o_link_reserved
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // every link pin released
  wire links_off = o_csi_data_out_oe_n & o_handshake_pin_oe_n & o_uart_transmit_pin_oe_n;

  a_mode_exclusive: assert property (!(o_normal_mode && o_program_mode))
    else $error("both modes shown at once");
  a_mode_held: assert property ((o_normal_mode || o_program_mode)
    |=> $stable({o_normal_mode, o_program_mode})) else $error("mode changed without reset");
  a_normal_ports: assert property (o_normal_mode && $past(o_normal_mode)
    |-> o_port_oe_n == $past(i_app_port_oe_n)) else $error("ports not under application");
  a_prog_ports_off: assert property (o_program_mode && $past(o_program_mode)
    |-> &o_port_oe_n) else $error("port driven in programming mode");
  a_normal_links_off: assert property (o_normal_mode |-> links_off)
    else $error("link pin driven in normal mode");
  a_one_link: assert property (!(!o_csi_data_out_oe_n && !o_uart_transmit_pin_oe_n))
    else $error("two links driven");
  a_hs_with_csi: assert property (!o_handshake_pin_oe_n |-> !o_csi_data_out_oe_n)
    else $error("handshake without clocked link");
  a_reserved_off: assert property (o_link_reserved |-> links_off && o_program_mode)
    else $error("reserved selection drives a link");
  a_hs_pulse: assert property (!o_handshake_pin_oe_n && $fell(o_handshake_pin)
    |=> o_handshake_pin) else $error("handshake low too long");

  // main scenarios reached
  c_normal: cover property (o_normal_mode);
  c_hs: cover property (!o_handshake_pin_oe_n && $fell(o_handshake_pin));
  c_uart: cover property (!o_uart_transmit_pin_oe_n);
  c_reserved: cover property (o_link_reserved);
endmodule : fpl_mode_link_props

`default_nettype wire

/* sim/fpl_mode_link_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module fpl_mode_link_tb;
  logic        clk, rst;                  // system clock, reset
  logic [15:0] app, port_oe_n;            // port enables in, out
  logic        en, qual, sck, si, rx;     // programmer drives
  logic        so, so_oe_n, hs, hs_oe_n;  // clocked link outputs
  logic        tx, tx_oe_n;               // async link outputs
  logic        normal, prog_m, rsv;       // mode status
  int          seed = 32'h9bf44cc7;       // fixed for repeatable runs
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] r32;
  logic [7:0]  cmds [6] = '{8'h00, 8'h32, 8'h40, 8'h9a, 8'hc5, 8'ha0};

  fpl_mode_link #(.SEL_QUIET_CYC(200)) uut (
    .i_clk_sys(clk), .i_reset(rst), .i_program_enable_pin(en),
    .i_program_qualifier_pin(qual), .i_csi_serial_clock(sck), .i_csi_data_in(si),
    .o_csi_data_out(so), .o_csi_data_out_oe_n(so_oe_n), .o_handshake_pin(hs),
    .o_handshake_pin_oe_n(hs_oe_n), .i_uart_receive_pin(rx), .o_uart_transmit_pin(tx),
    .o_uart_transmit_pin_oe_n(tx_oe_n), .i_app_port_oe_n(app), .o_port_oe_n(port_oe_n),
    .o_normal_mode(normal), .o_program_mode(prog_m), .o_link_reserved(rsv));

  fpl_prog_model prog (
    .i_clk_sys(clk), .i_so(so), .i_hs(hs), .i_tx(tx),
    .o_en(en), .o_qual(qual), .o_sck(sck), .o_si(si), .o_rx(rx));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // accepted command set gets ack, the rest nak
  function automatic logic [7:0] resp_for(input logic [7:0] c);
    return (c inside {8'h00, 8'h32, 8'h20, 8'h22, 8'h40, 8'h13,
                      8'h90, 8'h9a, 8'hc0, 8'hc5, 8'h70, 8'ha0}) ? 8'h06 : 8'h15;
  endfunction : resp_for

  // expected {data out, handshake, transmit, reserved} for a pulse count
  function automatic logic [15:0] exp_oe(input int n);
    logic csi;
    csi = (n == 8 || n == 11);
    return {12'h0, ~csi, n != 11, n != 0, !(csi || n == 0)};
  endfunction : exp_oe

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask : check

  // pins set before reset, sampled at release
  task automatic boot(input logic e, input logic q);
    prog.mode(e, q);
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : boot

  // clocked bytes; each reply belongs to the byte before
  task automatic csi_run();
    logic [7:0] b, r, prev;
    prev = 8'hff; // nothing answered yet
    for (int k = 0; k < 6; k++) begin
      b = k[0] ? 8'($random(seed)) : cmds[k];
      prog.csi_byte(b, r);
      check(16'(r), 16'(prev), "clocked reply");
      prev = resp_for(b);
    end
  endtask : csi_run

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    logic [7:0] b, r;
    logic       ok;
    int         cnt [5] = '{8, 11, 5, 12, 0};
    rst = 1'b1;
    app = 16'hffff;
    // normal mode, random qualifier, pins moved later
    r32 = $random(seed);
    boot(1'b0, r32[0]);
    @(posedge clk) app <= r32[31:16];
    repeat (3) @(posedge clk);
    check(16'({normal, prog_m}), 16'h2, "normal mode");
    check(port_oe_n, r32[31:16], "app ports");
    prog.mode(1'b1, ~r32[0]);
    repeat (10) @(posedge clk);
    check(16'({normal, prog_m}), 16'h2, "mode held");
    $display("test normal done");
    // both mode pins high
    boot(1'b1, 1'b1);
    check(16'({prog_m, rsv}), 16'h3, "prohibited pair");
    check(port_oe_n, 16'hffff, "ports off");
    $display("test prohibited done");
    foreach (cnt[i]) begin
      boot(1'b1, 1'b0);
      prog.pulses(cnt[i]);
      repeat (220) @(posedge clk);
      check(16'({so_oe_n, hs_oe_n, tx_oe_n, rsv}), exp_oe(cnt[i]), "link pins");
      check(port_oe_n, 16'hffff, "ports off");
      if (cnt[i] == 8 || cnt[i] == 11) csi_run();
      if (cnt[i] == 0) begin
        fork
          prog.uart_send(8'h00);
          prog.uart_recv(r, ok);
        join
        check(16'({ok, r}), 16'h106, "rate learn ack");
        b = 8'($random(seed));
        fork
          prog.uart_send(b);
          prog.uart_recv(r, ok);
        join
        check(16'({ok, r}), 16'({1'b1, resp_for(b)}), "async reply");
      end
      $display("test pulses %0d done", cnt[i]);
    end
    results();
  end
endmodule : fpl_mode_link_tb

bind fpl_mode_link fpl_mode_link_props u_props (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .o_csi_data_out_oe_n(o_csi_data_out_oe_n),
  .o_handshake_pin(o_handshake_pin), .o_handshake_pin_oe_n(o_handshake_pin_oe_n),
  .o_uart_transmit_pin_oe_n(o_uart_transmit_pin_oe_n), .i_app_port_oe_n(i_app_port_oe_n),
  .o_port_oe_n(o_port_oe_n), .o_normal_mode(o_normal_mode),
  .o_program_mode(o_program_mode), .o_link_reserved(o_link_reserved));

`default_nettype wire

/* sim/fpl_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none

module fpl_prog_model (
  // pacing clock
  input  wire logic i_clk_sys,
  // device outputs
  input  wire logic i_so,
  input  wire logic i_hs,
  input  wire logic i_tx,
  // programmer drives
  output logic      o_en,
  output logic      o_qual,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_rx
);
  localparam int BIT_NS = 6500; // near the top async rate

  // idle levels; serial clock stands high between frames
  initial begin
    o_en = 1'b0;
    o_qual = 1'b0;
    o_sck = 1'b1;
    o_si = 1'b1;
    o_rx = 1'b1;
  end

  // set both mode pins
  task automatic mode(input logic e, input logic q);
    @(posedge i_clk_sys);
    o_en <= e;
    o_qual <= q;
  endtask : mode

  // select pulses, low four cycles, high five between pulses
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk_sys) o_en <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      o_en <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask : pulses

  // one clocked byte, msb first, reply sampled on rising edge
  task automatic csi_byte(input logic [7:0] b, output logic [7:0] r);
    int i;
    i = 0;
    while (i_hs !== 1'b1 && i < 100) begin // wait ready, bounded
      @(posedge i_clk_sys);
      i++;
    end
    for (int k = 7; k >= 0; k--) begin
      o_sck <= 1'b0;
      o_si <= b[k];
      #16;
      o_sck <= 1'b1;
      r[k] = i_so;
      #16;
    end
    o_si <= ~b[0]; // released line shows no stale value
    #400;
  endtask : csi_byte

  // async frame, lsb first; a zero byte is the reset command
  task automatic uart_send(input logic [7:0] b);
    o_rx <= 1'b0;
    #BIT_NS;
    for (int k = 0; k < 8; k++) begin
      o_rx <= b[k];
      #BIT_NS;
    end
    o_rx <= 1'b1;
    #BIT_NS;
  endtask : uart_send

  // receive one reply frame, sampled mid bit
  task automatic uart_recv(output logic [7:0] r, output logic ok);
    int i;
    i = 0;
    while (i_tx !== 1'b0 && i < 20000) begin
      #10;
      i++;
    end
    #(BIT_NS * 3 / 2);
    for (int k = 0; k < 8; k++) begin
      r[k] = i_tx;
      #BIT_NS;
    end
    ok = (i_tx === 1'b1) && (i < 20000);
    #BIT_NS; // let the stop bit finish before the next command
  endtask : uart_recv
  // no debug reset pin is ever driven
endmodule : fpl_prog_model

`default_nettype wire
